// *** verilog/tcrp_timer.sv ***
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module tcrp_timer
  import tcrp_pkg::*;
(
  input  wire logic        mclk_in,            // 250 MHz clock
  input  wire logic        resetn_in,          // Async reset, low
  input  wire logic [4:0]  address_in,         // Byte address
  input  wire logic        read_in,            // Avalon read
  input  wire logic        write_in,           // Avalon write
  input  wire logic [3:0]  byteenable_in,      // Byte lanes
  input  wire logic [31:0] writedata_in,       // Write data
  output logic      [31:0] readdata_out,       // Read data
  output logic             waitrequest_out,    // Avalon wait
  input  wire logic [7:0]  trig_src_in,        // Trigger candidates
  input  wire logic [7:0]  clk_src_in,         // External count sources
  output logic             wide_overflow_out,  // Overflow event pulse
  output logic             irq_out,            // Timer interrupt
  output logic             clock_output_pin_out // PWM output pin
);
  import tcrp_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  tcrp_state_type s_reg;
  tcrp_state_type s_next;

  logic        pre_tick;
  logic [7:0]  ext_tick;
  logic        htick;
  logic        ltick;
  logic        trig_lvl;
  logic        fall;
  logic        rise;
  logic        edge_en;
  logic        hov;
  logic        lov;
  logic        ext_set;
  logic        acc;
  logic        acc_wr;
  logic        pwm;
  logic [7:0]  ctrl_rd;
  logic [7:0]  mode_rd;
  logic [7:0]  mode2_rd;
  logic        wr_lo;
  logic        wr_hi;

  always_comb
  begin
    s_next   = s_reg;
    hov      = 1'b0;
    lov      = 1'b0;
    ext_set  = 1'b0;
    // Synchronisers: first stage feeds only the second
    s_next.trig_s1  = trig_src_in;
    s_next.trig_s2  = s_reg.trig_s1;
    s_next.clk_s1   = clk_src_in;
    s_next.clk_s2   = s_reg.clk_s1;
    s_next.clk_prev = s_reg.clk_s2;
    pre_tick = (s_reg.pre_cnt == PRESCALE_LAST);
    s_next.pre_cnt = pre_tick ? 4'h0 : s_reg.pre_cnt + 4'h1;
    ext_tick = s_reg.clk_s2 & ~s_reg.clk_prev;

    // ****************************************************************
    // Clock source selection
    // ****************************************************************
    case ({s_reg.clock_source_select_high, s_reg.clock_prescale_select,
           s_reg.counter_timer_select})
      3'b000:  htick = pre_tick;
      3'b010:  htick = 1'b1;
      default: htick = ext_tick[{s_reg.clock_source_select_high,
                                 s_reg.clock_prescale_select,
                                 s_reg.counter_timer_select}];
    endcase
    case ({s_reg.low_clock_select, s_reg.low_prescale_select})
      2'b00:   ltick = pre_tick;
      2'b01:   ltick = 1'b1;
      2'b10:   ltick = ext_tick[LOW_EXT_A];
      default: ltick = ext_tick[LOW_EXT_B];
    endcase

    // Mux change may fake one edge; software should select first
    trig_lvl = s_reg.trig_s2[s_reg.trig_sel]
               ^ s_reg.edge_invert_control;
    s_next.trig_prev = trig_lvl;
    fall = s_reg.trig_prev & ~trig_lvl;
    rise = ~s_reg.trig_prev & trig_lvl;
    edge_en = (fall & s_reg.falling_edge_enable)
              | (rise & s_reg.rising_edge_enable);

    // ****************************************************************
    // Counting
    // ****************************************************************
    if (!s_reg.split_enable && s_reg.mode == TCRP_M_DUTY)
    begin
      if (s_reg.run_bit && s_reg.duty != TCRP_D_IDLE && htick)
      begin
        hov = (s_reg.cnt == 16'hffff);
        s_next.cnt = s_reg.cnt + 16'h0001;
      end
      case (s_reg.duty)
        TCRP_D_IDLE:
        begin
          if (s_reg.run_bit && rise)
          begin
            s_next.duty = TCRP_D_ONE;
            s_next.cnt  = 16'h0000;
          end
        end
        TCRP_D_ONE:
        begin
          if (rise | fall)
          begin
            s_next.cap  = s_reg.cnt;
            ext_set     = s_reg.falling_edge_enable;
            s_next.duty = TCRP_D_TWO;
          end
        end
        default:
        begin
          if (rise | fall)
          begin
            s_next.run_bit = 1'b0;
            s_next.cnt     = s_reg.cnt;
            ext_set        = s_reg.rising_edge_enable;
            s_next.duty    = TCRP_D_IDLE;
          end
        end
      endcase
      if (!s_reg.run_bit)
        s_next.duty = TCRP_D_IDLE;
    end
    else if (!s_reg.split_enable)
    begin
      s_next.duty = TCRP_D_IDLE;
      if (s_reg.run_bit && htick)
      begin
        if (s_reg.cnt == 16'hffff)
        begin
          hov = 1'b1;
          s_next.cnt = (s_reg.mode == TCRP_M_RELOAD ||
                        s_reg.mode == TCRP_M_RELEDGE)
                       ? s_reg.cap : 16'h0000;
        end
        else
          s_next.cnt = s_reg.cnt + 16'h0001;
      end
      if (edge_en)
      begin
        ext_set = 1'b1;
        case (s_reg.mode)
          TCRP_M_RELEDGE: s_next.cnt = s_reg.cap;
          TCRP_M_CAPT:    s_next.cap = s_reg.cnt;
          TCRP_M_CAPZERO:
          begin
            s_next.cap = s_reg.cnt;
            s_next.cnt = 16'h0000;
          end
          default: ;
        endcase
      end
    end
    else
    begin
      s_next.duty = TCRP_D_IDLE;
      if (s_reg.run_bit && htick)
      begin
        if (s_reg.cnt[15:8] == 8'hff)
        begin
          hov = 1'b1;
          s_next.cnt[15:8] = s_reg.cap[15:8];
        end
        else
          s_next.cnt[15:8] = s_reg.cnt[15:8] + 8'h01;
      end
      if (hov && s_reg.low_run_auto_clear)
        s_next.low_run_bit = 1'b0;
      if (s_reg.mode == TCRP_M_PWM)
      begin
        if (hov)
          s_next.cnt[7:0] = s_reg.cap[7:0];
        // Trigger still flags here, though it moves no counter
        if (edge_en)
          ext_set = 1'b1;
      end
      else
      begin
        if (s_reg.low_run_bit && ltick)
        begin
          if (s_reg.cnt[7:0] == 8'hff)
          begin
            lov = 1'b1;
            s_next.cnt[7:0] = s_reg.cap[7:0];
          end
          else
            s_next.cnt[7:0] = s_reg.cnt[7:0] + 8'h01;
        end
        if (edge_en)
        begin
          ext_set = 1'b1;
          case (s_reg.mode)
            TCRP_M_RELEDGE: s_next.cnt[15:8] = s_reg.cap[15:8];
            TCRP_M_CAPT:    s_next.cap[15:8] = s_reg.cnt[15:8];
            TCRP_M_CAPZERO:
            begin
              s_next.cap[15:8] = s_reg.cnt[15:8];
              s_next.cnt[15:8] = 8'h00;
            end
            default: ;
          endcase
        end
      end
    end
    pwm = s_reg.cnt[15:8] < s_reg.cnt[7:0];

    // ****************************************************************
    // Register bus: one wait cycle, then the answer
    // ****************************************************************
    acc    = (read_in | write_in) & ~s_reg.wreq;
    acc_wr = acc & write_in;
    wr_lo  = acc_wr & byteenable_in[0];
    wr_hi  = acc_wr & byteenable_in[1];
    s_next.wreq = ~((read_in | write_in) & s_reg.wreq);
    ctrl_rd = {s_reg.overflow_flag, s_reg.external_flag,
               s_reg.bit_bank_select ? s_reg.low_overflow_flag
                                     : s_reg.receive_clock_select,
               s_reg.bit_bank_select ? s_reg.low_irq_enable
                                     : s_reg.transmit_clock_select,
               s_reg.falling_edge_enable, s_reg.run_bit,
               s_reg.counter_timer_select, 1'b0};
    mode_rd = {s_reg.split_enable,
               s_reg.bit_bank_select ? s_reg.edge_invert_control
                                     : s_reg.low_prescale_select,
               s_reg.low_run_bit, s_reg.low_run_auto_clear,
               s_reg.rising_edge_enable, s_reg.clock_prescale_select,
               s_reg.output_enable_bit, 1'b0};
    mode2_rd = {s_reg.bit_bank_select, s_reg.overflow_irq_ignore,
                s_reg.low_clock_select, s_reg.clock_source_select_high,
                1'b0, s_reg.trig_sel};
    s_next.rdata = 32'h0000_0000;
    if (address_in == CTRL_OFS)
      s_next.rdata[7:0] = ctrl_rd;
    else if (address_in == MODE_OFS)
      s_next.rdata[7:0] = mode_rd;
    else if (address_in == MODE2_OFS)
      s_next.rdata[7:0] = mode2_rd;
    else if (address_in == OPMODE_OFS)
      s_next.rdata[2:0] = s_reg.mode;
    else if (address_in == COUNT_OFS)
      s_next.rdata[15:0] = s_reg.cnt;
    else if (address_in == CAP_OFS)
      s_next.rdata[15:0] = s_reg.cap;

    if (wr_lo && address_in == CTRL_OFS)
    begin
      s_next.overflow_flag        = writedata_in[CTRL_OVF];
      s_next.external_flag        = writedata_in[CTRL_EXT];
      if (s_reg.bit_bank_select)
      begin
        s_next.low_overflow_flag  = writedata_in[CTRL_BANK5];
        s_next.low_irq_enable     = writedata_in[CTRL_BANK4];
      end
      else
      begin
        s_next.receive_clock_select  = writedata_in[CTRL_BANK5];
        s_next.transmit_clock_select = writedata_in[CTRL_BANK4];
      end
      s_next.falling_edge_enable  = writedata_in[CTRL_FALL];
      s_next.run_bit              = writedata_in[CTRL_RUN];
      s_next.counter_timer_select = writedata_in[CTRL_CT];
    end
    else if (wr_lo && address_in == MODE_OFS)
    begin
      s_next.split_enable = writedata_in[MODE_SPLIT];
      if (s_reg.bit_bank_select)
        s_next.edge_invert_control = writedata_in[MODE_BANK6];
      else
        s_next.low_prescale_select = writedata_in[MODE_BANK6];
      s_next.low_run_bit           = writedata_in[MODE_LRUN];
      s_next.low_run_auto_clear    = writedata_in[MODE_LRCLR];
      s_next.rising_edge_enable    = writedata_in[MODE_RISE];
      s_next.clock_prescale_select = writedata_in[MODE_PRESC];
      s_next.output_enable_bit     = writedata_in[MODE_OE];
    end
    else if (wr_lo && address_in == MODE2_OFS)
    begin
      s_next.bit_bank_select          = writedata_in[MODE2_BSEL];
      s_next.overflow_irq_ignore      = writedata_in[MODE2_IGN];
      s_next.low_clock_select         = writedata_in[MODE2_LCS];
      s_next.clock_source_select_high = writedata_in[MODE2_CKSH];
      s_next.trig_sel                 = writedata_in[2:0];
    end
    else if (wr_lo && address_in == OPMODE_OFS)
      s_next.mode = tcrp_mode_type'(writedata_in[2:0]);
    if (address_in == COUNT_OFS)
    begin
      if (wr_lo)
        s_next.cnt[7:0] = writedata_in[7:0];
      if (wr_hi)
        s_next.cnt[15:8] = writedata_in[15:8];
    end
    else if (address_in == CAP_OFS)
    begin
      if (wr_lo)
        s_next.cap[7:0] = writedata_in[7:0];
      if (wr_hi)
        s_next.cap[15:8] = writedata_in[15:8];
    end

    // Hardware sets win over a clearing write in the same cycle
    s_next.overflow_flag     = s_next.overflow_flag | hov;
    s_next.external_flag     = s_next.external_flag | ext_set;
    s_next.low_overflow_flag = s_next.low_overflow_flag | lov;
    s_next.ovf_evt = s_reg.split_enable ? lov : hov;
    s_next.irq = (s_next.overflow_flag & ~s_next.overflow_irq_ignore)
                 | s_next.external_flag
                 | (s_next.low_overflow_flag & s_next.low_irq_enable);
    s_next.pin = s_reg.split_enable && s_reg.mode == TCRP_M_PWM
                 && s_reg.output_enable_bit && pwm;
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_reg      <= '0;
      s_reg.cnt  <= COUNT_RST;
      s_reg.cap  <= CAP_RST;
      s_reg.wreq <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign readdata_out         = s_reg.rdata;
  assign waitrequest_out      = s_reg.wreq;
  assign wide_overflow_out    = s_reg.ovf_evt;
  assign irq_out              = s_reg.irq;
  assign clock_output_pin_out = s_reg.pin;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  reload_wrap_a: assert property (
    (!s_reg.split_enable && s_reg.mode == TCRP_M_RELEDGE && s_reg.run_bit
     && htick && s_reg.cnt == 16'hffff && !edge_en && !acc_wr)
    |=> (s_reg.cnt == $past(s_reg.cap)) && s_reg.overflow_flag)
    else $error("reload on wrap missing");
  fall_flag_a: assert property (
    (fall && s_reg.falling_edge_enable && !s_reg.split_enable
     && s_reg.mode != TCRP_M_DUTY) |=> s_reg.external_flag)
    else $error("falling edge did not set flag");
  rise_flag_a: assert property (
    (rise && s_reg.rising_edge_enable && s_reg.mode != TCRP_M_DUTY)
    |=> s_reg.external_flag)
    else $error("rising edge did not set flag");
  capture_value_a: assert property (
    (!s_reg.split_enable && s_reg.mode == TCRP_M_CAPT && edge_en
     && !acc_wr) |=> s_reg.cap == $past(s_reg.cnt))
    else $error("capture value wrong");
  auto_zero_a: assert property (
    (!s_reg.split_enable && s_reg.mode == TCRP_M_CAPZERO && edge_en
     && !acc_wr) |=> s_reg.cnt == 16'h0000)
    else $error("counter not zeroed");
  duty_first_a: assert property (
    (!s_reg.split_enable && s_reg.mode == TCRP_M_DUTY
     && s_reg.duty == TCRP_D_IDLE && !s_reg.external_flag && !acc_wr)
    |=> !s_reg.external_flag)
    else $error("first duty edge set flag");
  duty_stop_a: assert property (
    (!s_reg.split_enable && s_reg.mode == TCRP_M_DUTY
     && s_reg.duty == TCRP_D_TWO && (rise || fall) && !acc_wr)
    |=> !s_reg.run_bit ##1 $stable(s_reg.cnt))
    else $error("third edge did not stop");
  low_run_clr_a: assert property (
    (s_reg.split_enable && hov && s_reg.low_run_auto_clear && !acc_wr)
    |=> !s_reg.low_run_bit)
    else $error("low run not cleared");
  split_event_a: assert property (
    (s_reg.split_enable && lov) |=> wide_overflow_out)
    else $error("split overflow event missing");
  pin_gate_a: assert property (
    !s_reg.output_enable_bit |=> !clock_output_pin_out)
    else $error("pin driven while disabled");
  single_edge_a: assert property (
    fall |=> !fall)
    else $error("edge seen twice");
  bus_wait_a: assert property (
    !waitrequest_out |=> waitrequest_out)
    else $error("waitrequest low too long");

  reload_c: cover property (hov && s_reg.mode == TCRP_M_RELOAD);
  capture_c: cover property (edge_en && s_reg.mode == TCRP_M_CAPT);
  duty_c: cover property (s_reg.duty == TCRP_D_TWO ##[1:1000]
                          s_reg.duty == TCRP_D_IDLE);
  pwm_c: cover property (clock_output_pin_out ##1 !clock_output_pin_out);

endmodule : tcrp_timer

`default_nettype wire

// *** verilog/tcrp_pkg.sv ***
package tcrp_pkg;

  // ****************************************************************
  // Register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [4:0] CTRL_OFS   = 5'h00;
  localparam logic [4:0] MODE_OFS   = 5'h04;
  localparam logic [4:0] MODE2_OFS  = 5'h08;
  localparam logic [4:0] OPMODE_OFS = 5'h0c;
  localparam logic [4:0] COUNT_OFS  = 5'h10;
  localparam logic [4:0] CAP_OFS    = 5'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_OVF   = 7;
  localparam int CTRL_EXT   = 6;
  localparam int CTRL_BANK5 = 5;
  localparam int CTRL_BANK4 = 4;
  localparam int CTRL_FALL  = 3;
  localparam int CTRL_RUN   = 2;
  localparam int CTRL_CT    = 1;
  localparam int MODE_SPLIT = 7;
  localparam int MODE_BANK6 = 6;
  localparam int MODE_LRUN  = 5;
  localparam int MODE_LRCLR = 4;
  localparam int MODE_RISE  = 3;
  localparam int MODE_PRESC = 2;
  localparam int MODE_OE    = 1;
  localparam int MODE2_BSEL = 7;
  localparam int MODE2_IGN  = 6;
  localparam int MODE2_LCS  = 5;
  localparam int MODE2_CKSH = 4;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam logic [15:0] CAP_RST      = 16'h0000;
  localparam logic [3:0]  PRESCALE_DIV = 4'hc;
  localparam logic [3:0]  PRESCALE_LAST = PRESCALE_DIV - 4'h1;
  localparam int          LOW_EXT_A    = 2;
  localparam int          LOW_EXT_B    = 3;

  typedef enum logic [2:0] {
    TCRP_M_RELOAD  = 3'h0,
    TCRP_M_RELEDGE = 3'h1,
    TCRP_M_CAPT    = 3'h2,
    TCRP_M_CAPZERO = 3'h3,
    TCRP_M_PWM     = 3'h4,
    TCRP_M_RSV5    = 3'h5,
    TCRP_M_DUTY    = 3'h6,
    TCRP_M_RSV7    = 3'h7
  } tcrp_mode_type;

  typedef enum logic [1:0] {
    TCRP_D_IDLE = 2'b00,
    TCRP_D_ONE  = 2'b01,
    TCRP_D_TWO  = 2'b11
  } tcrp_duty_type;

  typedef struct packed {
    logic [7:0]    trig_s1;
    logic [7:0]    trig_s2;
    logic [7:0]    clk_s1;
    logic [7:0]    clk_s2;
    logic [7:0]    clk_prev;
    logic          trig_prev;
    logic [3:0]    pre_cnt;
    logic [15:0]   cnt;
    logic [15:0]   cap;
    logic          overflow_flag;
    logic          external_flag;
    logic          low_overflow_flag;
    logic          low_irq_enable;
    logic          receive_clock_select;
    logic          transmit_clock_select;
    logic          falling_edge_enable;
    logic          run_bit;
    logic          counter_timer_select;
    logic          split_enable;
    logic          low_prescale_select;
    logic          edge_invert_control;
    logic          low_run_bit;
    logic          low_run_auto_clear;
    logic          rising_edge_enable;
    logic          clock_prescale_select;
    logic          output_enable_bit;
    logic          bit_bank_select;
    logic          overflow_irq_ignore;
    logic          low_clock_select;
    logic          clock_source_select_high;
    logic [2:0]    trig_sel;
    tcrp_mode_type mode;
    tcrp_duty_type duty;
    logic          wreq;
    logic [31:0]   rdata;
    logic          ovf_evt;
    logic          irq;
    logic          pin;
  } tcrp_state_type;

endpackage : tcrp_pkg

// *** verification/tcrp_trig_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module tcrp_trig_model (
  input  wire logic       mclk_in,  // System clock
  input  wire logic [2:0] sel_in,   // Trigger line in use
  input  wire logic       level_in, // Wanted trigger level
  output logic      [7:0] trig_out, // Trigger candidates
  output logic      [7:0] clk_out   // External count sources
);
  // ******************************
  // Idle lines keep toggling
  // ******************************
  logic [8:0] noise_reg = 9'h000;

  always @(posedge mclk_in) noise_reg <= noise_reg + 9'h001;

  // Edges two cycles apart at least, as the synchronisers need
  always_comb
  begin
    trig_out = noise_reg[8:1];
    trig_out[sel_in] = level_in;
    clk_out = noise_reg[8:1];
  end
endmodule : tcrp_trig_model

`default_nettype wire

// *** verification/timer2_capture_reload_pwm_bench.sv ***
`timescale 1ns/1ns
`default_nettype none

module timer2_capture_reload_pwm_bench;
  import tcrp_pkg::*;
  logic        mclk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic [7:0]  trig;
  logic [7:0]  csrc;
  logic        lvl = 1'b1;
  logic [2:0]  tsel = 3'h0;
  logic        ovf;
  logic        irq;
  logic        pwm;
  logic [31:0] q;
  logic [15:0] c1;
  int          fails = 0;
  int          comparisons = 0;
  int          hi;

  always #2 mclk_in = ~mclk_in;

  tcrp_timer i_dut (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .address_in(addr), .read_in(rd), .write_in(wr),
    .byteenable_in(4'hf), .writedata_in(wdata), .readdata_out(rdata),
    .waitrequest_out(wait_req), .trig_src_in(trig), .clk_src_in(csrc),
    .wide_overflow_out(ovf), .irq_out(irq), .clock_output_pin_out(pwm));

  tcrp_trig_model i_trig (.mclk_in(mclk_in), .sel_in(tsel),
    .level_in(lvl), .trig_out(trig), .clk_out(csrc));

  // ******************************
  // Bus and check tasks
  // ******************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n = 0;
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= ~w;
    @(posedge mclk_in);
    while (wait_req !== 1'b0 && n < 20)
    begin
      @(posedge mclk_in);
      n++;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) chk(16'h0, 16'h1);
    @(posedge mclk_in);
  endtask : bus

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wreg

  task automatic rreg(input logic [4:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rreg

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : cyc

  task automatic give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // ******************************
  // Tests
  // ******************************
  initial
  begin
    void'($urandom(32'h6f8a));
    tsel = 3'($urandom());
    cyc(4);
    resetn_in <= 1'b1;
    cyc(1);
    wreg(5'h18, 32'hffff);
    for (int i = 0; i < 7; i++)
    begin
      rreg(5'(i * 4));
      chk(q[15:0], 16'h0);
    end
    chk(16'({ovf, irq, pwm}), 16'h0);
    $display("reset test done");
    c1 = {8'hff, 1'b0, 7'($urandom())};
    wreg(CAP_OFS, {16'h0, c1});
    wreg(COUNT_OFS, 32'hfffa);
    wreg(OPMODE_OFS, 32'h1);
    wreg(MODE_OFS, 32'h04);
    wreg(CTRL_OFS, 32'h04);
    hi = 0;
    while (ovf !== 1'b1 && hi < 100)
    begin
      @(posedge mclk_in);
      hi++;
    end
    chk(16'(ovf), 16'h1);
    rreg(CTRL_OFS);
    chk(16'(q[7] & irq), 16'h1);
    rreg(COUNT_OFS);
    chk(16'(q[15:0] >= c1), 16'h1);
    wreg(MODE2_OFS, 32'h40 | 32'(tsel));
    cyc(2);
    chk(16'(irq), 16'h0);
    $display("reload test done");
    wreg(MODE2_OFS, 32'(tsel));
    wreg(COUNT_OFS, 32'h0);
    wreg(OPMODE_OFS, 32'h2);
    wreg(CTRL_OFS, 32'h0c);
    cyc(10);
    lvl <= 1'b0;
    cyc(8);
    rreg(CTRL_OFS);
    chk(16'(q[6]), 16'h1);
    rreg(CAP_OFS);
    c1 = q[15:0];
    rreg(COUNT_OFS);
    chk(16'(q[15:0] > c1 && c1 > 16'h0), 16'h1);
    wreg(CTRL_OFS, 32'h0c);
    lvl <= 1'b1;
    cyc(8);
    rreg(CTRL_OFS);
    chk(16'(q[6]), 16'h0);
    wreg(OPMODE_OFS, 32'h3);
    wreg(MODE_OFS, 32'h0c);
    wreg(CTRL_OFS, 32'h04);
    lvl <= 1'b0;
    cyc(8);
    lvl <= 1'b1;
    cyc(4);
    rreg(COUNT_OFS);
    chk(16'(q[15:0] < 16'h20), 16'h1);
    rreg(CTRL_OFS);
    chk(16'(q[6]), 16'h1);
    $display("capture test done");
    wreg(CTRL_OFS, 32'h0);
    lvl <= 1'b0;
    wreg(COUNT_OFS, 32'h0);
    wreg(OPMODE_OFS, 32'h6);
    wreg(CTRL_OFS, 32'h0c);
    cyc(20);
    rreg(COUNT_OFS);
    chk(q[15:0], 16'h0);
    lvl <= 1'b1;
    cyc(30);
    rreg(CTRL_OFS);
    chk(16'(q[6]), 16'h0);
    lvl <= 1'b0;
    cyc(8);
    rreg(CTRL_OFS);
    chk(16'(q[6]), 16'h1);
    wreg(CTRL_OFS, 32'h0c);
    lvl <= 1'b1;
    cyc(8);
    rreg(CTRL_OFS);
    chk(16'(q[2]), 16'h0);
    rreg(COUNT_OFS);
    c1 = q[15:0];
    cyc(10);
    rreg(COUNT_OFS);
    chk(q[15:0], c1);
    $display("duty test done");
    wreg(CTRL_OFS, 32'h0);
    wreg(MODE2_OFS, 32'h80 | 32'(tsel));
    wreg(CAP_OFS, 32'h0040);
    // Compare byte preloaded so the first period is a full one too
    wreg(COUNT_OFS, 32'h0040);
    wreg(OPMODE_OFS, 32'h4);
    wreg(MODE_OFS, 32'h86);
    wreg(CTRL_OFS, 32'h04);
    hi = 0;
    repeat (512)
    begin
      @(posedge mclk_in);
      if (pwm === 1'b1) hi++;
    end
    // A quarter of each 256-tick period is high
    chk(16'(hi > 100 && hi < 160), 16'h1);
    rreg(CTRL_OFS);
    chk(16'(q[7]), 16'h1);
    wreg(MODE_OFS, 32'h84);
    cyc(4);
    hi = 0;
    repeat (256)
    begin
      @(posedge mclk_in);
      if (pwm !== 1'b0) hi++;
    end
    chk(16'(hi), 16'h0);
    $display("pwm test done");
    wreg(CTRL_OFS, 32'h0);
    wreg(OPMODE_OFS, 32'h0);
    wreg(MODE2_OFS, 32'ha0 | 32'(tsel));
    wreg(CAP_OFS, 32'hf0f0);
    wreg(COUNT_OFS, 32'hf0f0);
    wreg(MODE_OFS, 32'ha4);
    wreg(CTRL_OFS, 32'h14);
    hi = 0;
    while (ovf !== 1'b1 && hi < 600)
    begin
      @(posedge mclk_in);
      hi++;
    end
    // Low byte needs sixteen source edges sixteen cycles apart
    chk(16'(hi > 200 && hi < 400), 16'h1);
    rreg(CTRL_OFS);
    chk(16'({q[7], q[5], irq}), 16'h7);
    wreg(MODE_OFS, 32'hb4);
    cyc(40);
    rreg(MODE_OFS);
    chk(16'(q[5]), 16'h0);
    $display("split test done");
    give_verdict;
  end

  // Span is several times the expected run
  initial
  begin
    #40000;
    fails++;
    give_verdict;
  end
endmodule : timer2_capture_reload_pwm_bench

`default_nettype wire
